//--- common/ums_pkg.sv
// constants and carrier types for the modem status and baud divisor block
package ums_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [15:0] UMS_OFS_MODEM_LINE_STATUS = 16'hFFA6;
  localparam logic [15:0] UMS_OFS_BAUD_DIVISOR_LOW = 16'hFFA7;
  localparam logic [15:0] UMS_OFS_BAUD_DIVISOR_HIGH = 16'hFFA8;
  localparam logic [15:0] UMS_OFS_MODEM_LINE_CONTROL = 16'hFFB0;
  localparam logic [15:0] UMS_OFS_IRQ_STATUS = 16'hFFB1;
  localparam logic [15:0] UMS_OFS_IRQ_CLEAR = 16'hFFB2;
  localparam logic [15:0] UMS_OFS_IRQ_ENABLE = 16'hFFB3;

  // ****************************************************************
  // field positions
  // ****************************************************************
  // change flags of modem_line_status, also the interrupt bit layout
  localparam int UMS_BIT_CTS_CHANGED = 0;
  localparam int UMS_BIT_DSR_CHANGED = 1;
  localparam int UMS_BIT_RING_TRAILING = 2;
  localparam int UMS_BIT_CARRIER_CHANGED = 3;
  // level bits of modem_line_status and the looped bits of modem_line_control
  localparam int UMS_BIT_LOOP_CLEAR_TO_SEND = 4;
  localparam int UMS_BIT_LOOP_SET_READY = 5;
  localparam int UMS_BIT_LOOP_RING = 6;
  localparam int UMS_BIT_LOOP_CARRIER = 7;
  // loopback enable in modem_line_control
  localparam int UMS_BIT_LOOPBACK_EN = 0;
  localparam int UMS_FLAG_W = 4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] UMS_RST_MODEM_LINE_STATUS = 8'h00;
  localparam logic [7:0] UMS_RST_BAUD_DIVISOR_LOW = 8'h08;
  localparam logic [7:0] UMS_RST_BAUD_DIVISOR_HIGH = 8'h00;
  localparam logic [7:0] UMS_RST_MODEM_LINE_CONTROL = 8'h00;
  localparam logic [3:0] UMS_RST_IRQ = 4'h0;
  // synchronisers idle high: the modem lines are active low
  localparam logic [3:0] UMS_RST_PIN_SYNC = 4'hF;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int UMS_CLK_MHZ = 250;
  localparam int UMS_MASTER_MHZ = 96;
  // prescale of 6.5 held as twice its value
  localparam int UMS_PRESCALE_X2 = 13;
  localparam logic [15:0] UMS_REF_NUM = 16'(2 * UMS_MASTER_MHZ);
  localparam logic [15:0] UMS_REF_DEN = 16'(UMS_PRESCALE_X2 * UMS_CLK_MHZ);
  localparam logic [3:0] UMS_OVERSAMPLE_LAST = 4'hF;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } ums_req_t;

  // active-low modem control lines as seen on the pins
  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } ums_modem_t;

endpackage

//--- rtl/ums_baud_gen.sv
// baud reference and baud tick generator for the divisor registers
`timescale 1ns/100ps
module ums_baud_gen
  import ums_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [15:0] divisor,
  output logic ref_tick,
  output logic os_tick,
  output logic baud_tick
);

  // ****************************************************************
  // fractional prescaler
  // ****************************************************************
  // the reference runs at master/6.5, made here from ref_clk by a
  // phase accumulator; jitter is one ref_clk period, far below a bit
  logic [15:0] acc_q;
  logic [15:0] acc_d;
  logic [16:0] acc_sum;
  logic ref_hit;

  assign acc_sum = {1'b0, acc_q} + {1'b0, UMS_REF_NUM};
  assign ref_hit = acc_sum >= {1'b0, UMS_REF_DEN};
  assign acc_d = ref_hit ? 16'(acc_sum - {1'b0, UMS_REF_DEN}) : acc_sum[15:0];

  // ****************************************************************
  // divisor and oversample counters
  // ****************************************************************
  logic [15:0] div_cnt_q;
  logic [3:0] os_cnt_q;
  logic [15:0] div_last;
  logic div_hit;

  // a divisor of zero is run as one so the generator never stalls
  assign div_last = (divisor == 16'h0000) ? 16'h0000 : 16'(divisor - 16'h0001);
  assign div_hit = ref_tick && (div_cnt_q >= div_last); // [R12]

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      acc_q <= 16'h0000;
      ref_tick <= 1'b0;
      div_cnt_q <= 16'h0000;
      os_cnt_q <= 4'h0;
      os_tick <= 1'b0;
      baud_tick <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      ref_tick <= ref_hit; // [R12]
      os_tick <= div_hit;
      baud_tick <= div_hit && (os_cnt_q == UMS_OVERSAMPLE_LAST); // [R12]
      if (div_hit)
      begin
        div_cnt_q <= 16'h0000;
        os_cnt_q <= 4'(os_cnt_q + 4'h1);
      end
      else if (ref_tick)
      begin
        div_cnt_q <= 16'(div_cnt_q + 16'h0001);
      end
    end
  end

endmodule

//--- rtl/ums_modem_status.sv
// modem line status, baud divisor and modem interrupt registers
//
// What this block does
// [R1] clear-to-send change sets bit 0, sticky
// [R2] data-set-ready change sets bit 1, sticky
// [R3] ring input low-to-high sets bit 2
// [R4] carrier-detect change sets bit 3, sticky
// [R5] change flags clear only on written one
// [R6] loopback: bits 4 and 7 mirror control
// [R7] loopback: bits 5 and 6 mirror control
// [R8] status resets zero; level bits read-only
// [R9] divisor low byte is divisor bits 7..0
// [R10] divisor low byte resets to 08h
// [R11] divisor high byte gives bits 15..8
// [R12] reference is master over 6.5, then divisor*16
// [R13] normal mode: bits 4..7 show inverted pins
// [R14] loopback: change flags follow looped control bits
`timescale 1ns/100ps
module ums_modem_status
  import ums_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire ums_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire ums_modem_t modem_pins,
  output logic [15:0] baud_divisor,
  output logic loopback,
  output logic ref_tick,
  output logic os_tick,
  output logic baud_tick,
  output logic irq
);

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire hit_status = bus_req.addr == UMS_OFS_MODEM_LINE_STATUS;
  wire hit_div_low = bus_req.addr == UMS_OFS_BAUD_DIVISOR_LOW;
  wire hit_div_high = bus_req.addr == UMS_OFS_BAUD_DIVISOR_HIGH;
  wire hit_control = bus_req.addr == UMS_OFS_MODEM_LINE_CONTROL;
  wire hit_irq_status = bus_req.addr == UMS_OFS_IRQ_STATUS;
  wire hit_irq_clear = bus_req.addr == UMS_OFS_IRQ_CLEAR;
  wire hit_irq_enable = bus_req.addr == UMS_OFS_IRQ_ENABLE;

  wire wr_status = bus_req.wr && hit_status;
  wire wr_div_low = bus_req.wr && hit_div_low;
  wire wr_div_high = bus_req.wr && hit_div_high;
  wire wr_control = bus_req.wr && hit_control;
  wire wr_irq_clear = bus_req.wr && hit_irq_clear;
  wire wr_irq_enable = bus_req.wr && hit_irq_enable;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // three stages; a change is taken only once stages two and three
  // agree, which also filters single-cycle glitches on the lines
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync3_q;
  logic [3:0] pin_filt_q;
  logic [3:0] pin_filt_d;

  assign pin_filt_d = (sync2_q & ~(sync2_q ^ sync3_q)) | (pin_filt_q & (sync2_q ^ sync3_q));

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      sync1_q <= UMS_RST_PIN_SYNC;
      sync2_q <= UMS_RST_PIN_SYNC;
      sync3_q <= UMS_RST_PIN_SYNC;
      pin_filt_q <= UMS_RST_PIN_SYNC;
    end
    else
    begin
      sync1_q <= modem_pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_filt_q <= pin_filt_d;
    end
  end

  // ****************************************************************
  // control and divisor registers
  // ****************************************************************
  logic [7:0] control_q;
  logic [7:0] div_low_q;
  logic [7:0] div_high_q;
  logic [3:0] irq_enable_q;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      control_q <= UMS_RST_MODEM_LINE_CONTROL;
      div_low_q <= UMS_RST_BAUD_DIVISOR_LOW; // [R10]
      div_high_q <= UMS_RST_BAUD_DIVISOR_HIGH; // [R11]
      irq_enable_q <= UMS_RST_IRQ;
    end
    else
    begin
      if (wr_control)
      begin
        control_q <= bus_req.wdata;
      end
      if (wr_div_low)
      begin
        div_low_q <= bus_req.wdata; // [R9]
      end
      if (wr_div_high)
      begin
        div_high_q <= bus_req.wdata; // [R11]
      end
      if (wr_irq_enable)
      begin
        irq_enable_q <= bus_req.wdata[3:0];
      end
    end
  end

  assign loopback = control_q[UMS_BIT_LOOPBACK_EN];
  assign baud_divisor = {div_high_q, div_low_q}; // [R9] [R11]

  // ****************************************************************
  // observed modem levels
  // ****************************************************************
  // level vector is active high: [0] cts, [1] dsr, [2] ring, [3] carrier
  logic [3:0] pin_level;
  logic [3:0] loop_level;
  logic [3:0] level;

  assign pin_level = ~pin_filt_q; // [R13]
  assign loop_level = control_q[UMS_BIT_LOOP_CARRIER:UMS_BIT_LOOP_CLEAR_TO_SEND]; // [R6] [R7]
  assign level = loopback ? loop_level : pin_level; // [R14]

  // ****************************************************************
  // change detection
  // ****************************************************************
  // switching loopback on or off can itself flag a change, since the
  // seen level really moves; software should clear flags afterwards
  logic [3:0] level_q;
  logic [3:0] flag_set;
  logic [3:0] level_toggled;

  assign level_toggled = level ^ level_q;
  assign flag_set[UMS_BIT_CTS_CHANGED] = level_toggled[UMS_BIT_CTS_CHANGED]; // [R1]
  assign flag_set[UMS_BIT_DSR_CHANGED] = level_toggled[UMS_BIT_DSR_CHANGED]; // [R2]
  // ring pin rising low to high is the end of a ring, the active level falling
  assign flag_set[UMS_BIT_RING_TRAILING] = level_q[UMS_BIT_RING_TRAILING]
                                           && !level[UMS_BIT_RING_TRAILING]; // [R3]
  assign flag_set[UMS_BIT_CARRIER_CHANGED] = level_toggled[UMS_BIT_CARRIER_CHANGED]; // [R4]

  // ****************************************************************
  // change flags
  // ****************************************************************
  logic [3:0] flag_q;
  logic [3:0] flag_d;
  logic [3:0] flag_clear;

  assign flag_clear = wr_status ? bus_req.wdata[3:0] : 4'h0; // [R5]
  // a change arriving with the clearing write wins over it
  assign flag_d = (flag_q & ~flag_clear) | flag_set; // [R1] [R2] [R3] [R4] [R5]

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      level_q <= UMS_RST_MODEM_LINE_STATUS[7:4];
      flag_q <= UMS_RST_MODEM_LINE_STATUS[3:0]; // [R8]
    end
    else
    begin
      level_q <= level;
      flag_q <= flag_d;
    end
  end

  // ****************************************************************
  // status image
  // ****************************************************************
  // upper bits are wired straight from the level, so writes cannot
  // reach them
  logic [7:0] status_image;

  assign status_image = {level, flag_q}; // [R6] [R7] [R8] [R13]

  // ****************************************************************
  // interrupt
  // ****************************************************************
  logic [3:0] irq_stat_q;
  logic [3:0] irq_stat_d;
  logic [3:0] irq_clear;
  logic irq_q;

  assign irq_clear = wr_irq_clear ? bus_req.wdata[3:0] : 4'h0;
  assign irq_stat_d = (irq_stat_q & ~irq_clear) | flag_set;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      irq_stat_q <= UMS_RST_IRQ;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_d & irq_enable_q);
    end
  end

  assign irq = irq_q;

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;

  assign rd_mux = hit_status ? status_image
                : hit_div_low ? div_low_q
                : hit_div_high ? div_high_q
                : hit_control ? control_q
                : hit_irq_status ? {4'h0, irq_stat_q}
                : hit_irq_enable ? {4'h0, irq_enable_q}
                : 8'h00;

  // data stand one cycle after the read strobe and are zero otherwise
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      rdata_q <= 8'h00;
    end
    else
    begin
      rdata_q <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

  assign bus_rdata = rdata_q;

  // ****************************************************************
  // baud generator
  // ****************************************************************
  ums_baud_gen u_baud_gen (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .divisor(baud_divisor),
    .ref_tick(ref_tick),
    .os_tick(os_tick),
    .baud_tick(baud_tick)
  );

endmodule

//--- tb/test_ums_modem_status.sv
// self-checking bench for the modem status and baud divisor block
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module test_ums_modem_status;
  import ums_pkg::*;
  logic ref_clk, rstn, slow, irq, loopback;
  ums_req_t req;
  ums_modem_t pins;
  logic [15:0] div;
  logic [7:0] rdata, got, lo, hi;
  logic [3:0] want, en, prev, lv, v, v2;
  int bad_count, checks_done, cyc;
  logic ref_tk, os_tk, baud_tk, win, win_q;
  int refs, oss, bauds;
  ums_modem_status dut (.ref_clk(ref_clk), .rstn(rstn), .bus_req(req), .bus_rdata(rdata),
    .modem_pins(pins), .baud_divisor(div), .loopback(loopback), .ref_tick(ref_tk),
    .os_tick(os_tk), .baud_tick(baud_tk), .irq(irq));
  ums_modem_partner modem (.ref_clk(ref_clk), .rstn(rstn), .want(want), .slow(slow),
    .pins(pins));
  // ********
  // helpers
  // ********
  function automatic logic [3:0] flags(input logic [3:0] o, input logic [3:0] n);
    return {o[3] ^ n[3], o[2] & ~n[2], o[1] ^ n[1], o[0] ^ n[0]};
  endfunction
  task op(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk) req <= {w, r, a, d};
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
    op(1'b0, 1'b0, 16'h0000, 8'h00);
  endtask
  task rd(input logic [15:0] a);
    op(1'b0, 1'b1, a, 8'h00);
    op(1'b0, 1'b0, 16'h0000, 8'h00);
    #1 got = rdata;
  endtask
  task give_verdict;
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 9000)
    begin
      bad_count++;
      give_verdict;
    end
  end
  // tick counts over a window of whole accumulator periods
  always @(posedge ref_clk)
  begin
    win_q <= win;
    if (win && ref_tk)
      refs++;
    if (win_q && os_tk)
      oss++;
    if (win_q && baud_tk)
      bauds++;
  end
  // ********
  // scenarios
  // ********
  initial
  begin
    req = '0;
    rstn = 1'b0;
    want = 4'h0;
    slow = 1'b0;
    prev = 4'h0;
    win = 1'b0;
    void'($urandom(92));
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(16'hFFA6); `CHK(got, 8'h00)
    rd(16'hFFA7); `CHK(got, 8'h08)
    `CHK(div, 16'h0008)
    wr(16'hFFA6, 8'hF0); rd(16'hFFA6); `CHK(got, 8'h00)
    for (int i = 0; i < 4; i++)
    begin
      lo = i ? 8'($urandom) : 8'hFF;
      hi = 8'($urandom);
      wr(16'hFFA7, lo); wr(16'hFFA8, hi); rd(16'hFFA7); `CHK(got, lo)
      `CHK(div, {hi, lo})
    end
    for (int i = 0; i < 8; i++)
    begin
      en = 4'($urandom);
      lv = (i < 2) ? ~prev : 4'($urandom);
      wr(16'hFFB3, {4'h0, en});
      @(posedge ref_clk)
      begin
        want <= lv;
        slow <= 1'($urandom);
      end
      repeat (10) @(posedge ref_clk);
      rd(16'hFFA6); `CHK(got, {lv, flags(prev, lv)})
      `CHK(irq, |(flags(prev, lv) & en))
      op(1'b0, 1'b1, 16'hFFA6, 8'h00);
      op(1'b1, 1'b0, 16'hFFA6, 8'h00);
      rd(16'hFFA6); `CHK(got[3:0], flags(prev, lv))
      wr(16'hFFA6, 8'h0F); wr(16'hFFB2, 8'h0F); rd(16'hFFA6); `CHK(got, {lv, 4'h0})
      `CHK(irq, 1'b0)
      prev = lv;
    end
    for (int i = 0; i < 3; i++)
    begin
      v = 4'($urandom);
      v2 = i ? 4'($urandom) : ~v;
      wr(16'hFFB0, {v, 4'h1}); repeat (6) @(posedge ref_clk);
      rd(16'hFFA6); `CHK(got[7:4], v)
      `CHK(loopback, 1'b1)
      wr(16'hFFA6, 8'h0F); wr(16'hFFB2, 8'h0F); wr(16'hFFB0, {v2, 4'h1});
      repeat (8) @(posedge ref_clk);
      rd(16'hFFA6); `CHK(got, {v2, flags(v, v2)})
    end
    // divisor one: every reference tick is an oversample tick
    wr(16'hFFA8, 8'h00); wr(16'hFFA7, 8'h01);
    @(posedge ref_clk) win <= 1'b1;
    repeat (3250) @(posedge ref_clk);
    win <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK(refs, 192)
    `CHK(oss, 192)
    `CHK(bauds, 12)
    give_verdict;
  end
endmodule
bind ums_modem_status ums_modem_properties u_props (.ref_clk(ref_clk), .rstn(rstn),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .modem_pins(modem_pins),
  .baud_divisor(baud_divisor), .loopback(loopback), .irq(irq));

//--- tb/ums_modem_partner.sv
// modem model driving the active-low control lines
`timescale 1ns/100ps
module ums_modem_partner
  import ums_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [3:0] want,
  input wire logic slow,
  output ums_modem_t pins
);
  logic [3:0] lag_q;
  // a slow modem answers one cycle later than a prompt one
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      lag_q <= 4'h0;
      pins <= 4'hF;
    end
    else
    begin
      lag_q <= want;
      pins <= ~(slow ? lag_q : want);
    end
  end
endmodule

//--- tb/ums_modem_properties.sv
// port checker for the modem status and baud divisor block
`timescale 1ns/100ps
module ums_modem_properties
  import ums_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire ums_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire ums_modem_t modem_pins,
  input wire logic [15:0] baud_divisor,
  input wire logic loopback,
  input wire logic irq
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  sequence s_rd_status;
    bus_req.rd && bus_req.addr == UMS_OFS_MODEM_LINE_STATUS;
  endsequence
  property p_div_reset;
    disable iff (1'b0) !rstn |=> baud_divisor == 16'h0008;
  endproperty
  property p_rdata_reset;
    disable iff (1'b0) !rstn |=> bus_rdata == 8'h00 && !irq;
  endproperty
  property p_low_write;
    bus_req.wr && bus_req.addr == UMS_OFS_BAUD_DIVISOR_LOW
      |=> baud_divisor[7:0] == $past(bus_req.wdata);
  endproperty
  property p_high_write;
    bus_req.wr && bus_req.addr == UMS_OFS_BAUD_DIVISOR_HIGH
      |=> baud_divisor[15:8] == $past(bus_req.wdata);
  endproperty
  // the synchronisers need a settled line, hence six quiet cycles first
  property p_levels;
    (!loopback && $stable(modem_pins))[*6] ##0 s_rd_status
      |=> bus_rdata[7:4] == ~4'($past(modem_pins));
  endproperty
  property p_cts_flag;
    $changed(modem_pins.cts_n) && !loopback ##1 ((!loopback && !bus_req.wr &&
      $stable(modem_pins.cts_n)) throughout ##[6:20] s_rd_status) |=> bus_rdata[0];
  endproperty
  property p_cd_flag;
    $changed(modem_pins.cd_n) && !loopback ##1 ((!loopback && !bus_req.wr &&
      $stable(modem_pins.cd_n)) throughout ##[6:20] s_rd_status) |=> bus_rdata[3];
  endproperty
  property p_write_zero;
    s_rd_status ##1 (bus_rdata[0] && bus_req.wr && !bus_req.wdata[0] &&
      bus_req.addr == UMS_OFS_MODEM_LINE_STATUS) ##1 s_rd_status |=> bus_rdata[0];
  endproperty
  property p_loop_mirror;
    logic [3:0] v;
    (bus_req.wr && bus_req.addr == UMS_OFS_MODEM_LINE_CONTROL && bus_req.wdata[0],
      v = bus_req.wdata[7:4]) ##1 (!bus_req.wr throughout ##[3:20] s_rd_status)
      |=> bus_rdata[7:4] == v;
  endproperty
  a_div_reset: assert property (p_div_reset)
    else $error("divisor not 0008 after reset");
  a_rdata_reset: assert property (p_rdata_reset)
    else $error("read data or irq not idle in reset");
  a_low_write: assert property (p_low_write)
    else $error("divisor low byte not written");
  a_high_write: assert property (p_high_write)
    else $error("divisor high byte not written");
  a_levels: assert property (p_levels)
    else $error("status levels differ from lines");
  a_cts_flag: assert property (p_cts_flag)
    else $error("clear-to-send change not flagged");
  a_cd_flag: assert property (p_cd_flag)
    else $error("carrier change not flagged");
  a_write_zero: assert property (p_write_zero)
    else $error("zero write cleared a flag");
  a_loop_mirror: assert property (p_loop_mirror)
    else $error("loopback levels differ from control");
endmodule
